//--- verilog/qifs_top.sv
// queue count, interrupt coalescing and related set-feature handling
`timescale 1ns/1ps
`default_nettype none
module qifs_top
    import qifs_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input  wire logic             clk_sys,         // system clock
    input  wire logic             rst_b,           // async reset, active low
    input  wire logic [7:0]       reg_addr,        // register byte address
    input  wire logic [31:0]      reg_wdata,       // register write data
    input  wire logic             reg_wr,          // write strobe
    input  wire logic             reg_rd,          // read strobe
    output logic      [31:0]      reg_rdata,       // read data, cycle after strobe
    input  wire logic             cmd_valid,       // set-feature command offered
    input  wire logic [7:0]       cmd_fid,         // feature identifier
    input  wire logic [31:0]      cmd_dw11,        // command dword 11
    output logic                  cmd_ready,       // command can be taken
    output logic                  cpl_valid,       // completion entry, pulse
    output logic      [31:0]      cpl_dw0,         // completion dword 0
    output logic      [7:0]       cpl_status,      // completion status code
    input  wire logic             post_valid,      // completion entry posted to a CQ
    input  wire logic [VEC_W-1:0] post_vec,        // vector of that CQ
    input  wire logic             post_admin,      // posted to the admin CQ
    input  wire logic             post_error,      // posted with error status
    input  wire logic             db_write,        // CQ head doorbell write
    input  wire logic [VEC_W-1:0] db_vec,          // vector of that CQ
    output logic                  vec_irq_valid,   // vector interrupt, pulse
    output logic      [VEC_W-1:0] vec_irq_vec,     // vector to signal
    input  wire logic [15:0]      crit_warn,       // health critical warning bits
    output logic                  aen_valid,       // async event notice, pulse
    output logic      [15:0]      aen_bits,        // warnings that rose
    output logic                  normal_atomic_unit_off, // power-fail unit only
    output logic      [7:0]       preboot_load_counter,   // pre-boot load count
    output logic                  irq              // level interrupt
);
    qifs_coal_if cif ();

    qifs_state_t        state_reg;
    logic [7:0]         fid_reg;
    logic [31:0]        dw_reg;
    logic               alloc_done_reg;
    logic [15:0]        cq_count_allocated;
    logic [15:0]        sq_count_allocated;
    logic [7:0]         time_reg;
    logic [7:0]         thr_reg;
    logic [15:0]        aen_en_reg;
    logic [15:0]        warn_d_reg;
    logic [EV_W-1:0]    status_reg;
    logic [EV_W-1:0]    mask_reg;
    logic               tick;
    logic               fire_valid;
    logic [VEC_W-1:0]   fire_vec;
    logic [15:0]        cq_count_requested;
    logic [15:0]        sq_count_requested;
    logic [15:0]        warn_rise;
    logic               fid_known;
    logic               vec_bad;
    logic               apply;
    logic [EV_W-1:0]    ev_set;
    logic               wr_status;

    function automatic logic [15:0] clamp(input logic [15:0] req, input logic [15:0] lim);
        return (req > lim) ? lim : req;
    endfunction

    assign cq_count_requested = dw_reg[31:CNT_CQ_LSB];
    assign sq_count_requested = dw_reg[CNT_CQ_LSB-1:0];
    assign fid_known = (fid_reg == FID_NUM_QUEUES) || (fid_reg == FID_COALESCE) ||
                       (fid_reg == FID_VEC_CFG) || (fid_reg == FID_ATOMIC) ||
                       (fid_reg == FID_ASYNC_EV) || (fid_reg == FID_PROGRESS);
    // only vectors this controller has may be configured
    assign vec_bad   = (fid_reg == FID_VEC_CFG) && (dw_reg[15:0] >= 16'(NUM_VEC));
    assign apply     = (state_reg == ST_APPLY) && fid_known && !vec_bad;
    assign warn_rise = crit_warn & ~warn_d_reg & aen_en_reg;

    qifs_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .tick    (tick)
    );

    qifs_coal u_coal (
        .clk_sys    (clk_sys),
        .rst_b      (rst_b),
        .cfg        (cif.coal),
        .tick       (tick),
        .post_valid (post_valid),
        .post_vec   (post_vec),
        .post_admin (post_admin),
        .post_error (post_error),
        .db_write   (db_write),
        .db_vec     (db_vec),
        .fire_valid (fire_valid),
        .fire_vec   (fire_vec)
    );

    assign cif.agg_time                    = time_reg;
    assign cif.aggregation_entry_threshold = thr_reg;
    assign cif.cfg_we                      = apply && fid_reg == FID_VEC_CFG;
    assign cif.vector_select               = dw_reg[VEC_W-1:0];
    assign cif.vector_coalesce_off         = dw_reg[VOFF_BIT];

    // command sequencing: take, apply, post one completion
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            fid_reg   <= 8'h00;
            dw_reg    <= 32'h0000_0000;
            cmd_ready <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    cmd_ready <= 1'b1;
                    if (cmd_valid && cmd_ready) begin
                        fid_reg   <= cmd_fid;
                        dw_reg    <= cmd_dw11;
                        cmd_ready <= 1'b0;
                        state_reg <= ST_APPLY;
                    end
                end
                ST_APPLY: begin
                    state_reg <= ST_POST;
                end
                ST_POST: begin
                    cmd_ready <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                default: begin
                    cmd_ready <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cpl_valid  <= 1'b0;
            cpl_dw0    <= 32'h0000_0000;
            cpl_status <= ST_OK;
        end else begin
            cpl_valid <= (state_reg == ST_APPLY);
            if (state_reg == ST_APPLY) begin
                cpl_status <= apply ? ST_OK : ST_INV_FIELD;
                if (fid_reg == FID_NUM_QUEUES) begin
                    // before the first allocation report what it will be
                    cpl_dw0 <= alloc_done_reg ? {cq_count_allocated, sq_count_allocated} :
                               {clamp(cq_count_requested, MAX_CQ_ZB),
                                clamp(sq_count_requested, MAX_SQ_ZB)};
                end else begin
                    cpl_dw0 <= 32'h0000_0000;
                end
            end
        end
    end

    // a second request returns the first allocation unchanged
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            alloc_done_reg     <= 1'b0;
            cq_count_allocated <= 16'h0000;
            sq_count_allocated <= 16'h0000;
        end else if (apply && fid_reg == FID_NUM_QUEUES && !alloc_done_reg) begin
            alloc_done_reg     <= 1'b1;
            cq_count_allocated <= clamp(cq_count_requested, MAX_CQ_ZB);
            sq_count_allocated <= clamp(sq_count_requested, MAX_SQ_ZB);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            time_reg <= TIME_RST;
            thr_reg  <= THR_RST;
        end else if (apply && fid_reg == FID_COALESCE) begin
            time_reg <= dw_reg[15:TIME_LSB];
            thr_reg  <= dw_reg[TIME_LSB-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            normal_atomic_unit_off <= DN_RST;
        end else if (apply && fid_reg == FID_ATOMIC) begin
            normal_atomic_unit_off <= dw_reg[DN_BIT];
        end
    end

    // count is cleared only by reset or by a set-feature writing zero; power states do not touch it
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            preboot_load_counter <= PREBOOT_LOAD_COUNTER_RST;
        end else if (apply && fid_reg == FID_PROGRESS) begin
            preboot_load_counter <= dw_reg[7:0];
        end
    end

    // warnings already high when enabled do not raise a notice until they fall and rise
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            aen_en_reg <= AEN_RST;
            warn_d_reg <= 16'h0000;
            aen_valid  <= 1'b0;
            aen_bits   <= 16'h0000;
        end else begin
            if (apply && fid_reg == FID_ASYNC_EV) aen_en_reg <= dw_reg[15:0];
            warn_d_reg <= crit_warn;
            aen_valid  <= |warn_rise;
            aen_bits   <= warn_rise;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            vec_irq_valid <= 1'b0;
            vec_irq_vec   <= '0;
        end else begin
            vec_irq_valid <= fire_valid;
            vec_irq_vec   <= fire_vec;
        end
    end

    // sticky events, write one to clear, a new event wins over its clear
    assign ev_set    = {(state_reg == ST_APPLY) && !apply, |warn_rise, state_reg == ST_APPLY};
    assign wr_status = reg_wr && reg_addr == ADDR_STATUS;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            status_reg <= '0;
            mask_reg   <= MASK_RST;
            irq        <= 1'b0;
        end else begin
            status_reg <= (status_reg & ~(wr_status ? reg_wdata[EV_W-1:0] : '0)) | ev_set;
            if (reg_wr && reg_addr == ADDR_MASK) mask_reg <= reg_wdata[EV_W-1:0];
            irq <= |(status_reg & mask_reg);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_STATUS: reg_rdata <= 32'(status_reg);
                ADDR_MASK:   reg_rdata <= 32'(mask_reg);
                ADDR_ALLOC:  reg_rdata <= {cq_count_allocated, sq_count_allocated};
                ADDR_COAL:   reg_rdata <= {16'h0000, time_reg, thr_reg};
                ADDR_MISC:   reg_rdata <= {alloc_done_reg, 14'h0000, normal_atomic_unit_off, aen_en_reg};
                ADDR_PREBOOT_LOAD_COUNTER:  reg_rdata <= {24'h000000, preboot_load_counter};
                ADDR_VOFF:   reg_rdata <= 32'(cif.off_flags);
                default:     reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

//--- common/qifs_pkg.sv
// shared constants of the queue and interrupt feature settings block
package qifs_pkg;
    localparam int          NUM_VEC       = 8;
    localparam int          VEC_W         = 3;
    // feature identifiers
    localparam logic [7:0]  FID_NUM_QUEUES = 8'h07;
    localparam logic [7:0]  FID_COALESCE   = 8'h08;
    localparam logic [7:0]  FID_VEC_CFG    = 8'h09;
    localparam logic [7:0]  FID_ATOMIC     = 8'h0A;
    localparam logic [7:0]  FID_ASYNC_EV   = 8'h0B;
    localparam logic [7:0]  FID_PROGRESS   = 8'h80;
    // completion status codes
    localparam logic [7:0]  ST_OK          = 8'h00;
    localparam logic [7:0]  ST_INV_FIELD   = 8'h02;
    // highest zero-based queue counts the controller can allocate
    localparam logic [15:0] MAX_SQ_ZB      = 16'h000F;
    localparam logic [15:0] MAX_CQ_ZB      = 16'h000F;
    // command dword field positions
    localparam int          CNT_CQ_LSB     = 16;
    localparam int          TIME_LSB       = 8;
    localparam int          VOFF_BIT       = 16;
    localparam int          DN_BIT         = 0;
    // register byte addresses
    localparam logic [7:0]  ADDR_STATUS    = 8'h00;
    localparam logic [7:0]  ADDR_MASK      = 8'h04;
    localparam logic [7:0]  ADDR_ALLOC     = 8'h08;
    localparam logic [7:0]  ADDR_COAL      = 8'h0C;
    localparam logic [7:0]  ADDR_MISC      = 8'h10;
    localparam logic [7:0]  ADDR_PREBOOT_LOAD_COUNTER     = 8'h14;
    localparam logic [7:0]  ADDR_VOFF      = 8'h18;
    // status and mask bits
    localparam int          EV_W           = 3;
    localparam int          EV_CPL         = 0;
    localparam int          EV_AEN         = 1;
    localparam int          EV_INV         = 2;
    // reset values
    localparam logic [7:0]  THR_RST        = 8'h00;
    localparam logic [7:0]  TIME_RST       = 8'h00;
    localparam logic [15:0] AEN_RST        = 16'h0000;
    localparam logic [7:0]  PREBOOT_LOAD_COUNTER_RST      = 8'h00;
    localparam logic        DN_RST         = 1'b0;
    localparam logic [2:0]  MASK_RST       = 3'h0;
    // aggregation time unit
    localparam int          TICK_US        = 100;
    localparam int          CLK_MHZ        = 125;
    localparam int          TICK_CYC       = TICK_US * CLK_MHZ;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_APPLY = 2'b01,
        ST_POST  = 2'b11
    } qifs_state_t;
endpackage

//--- common/qifs_coal_if.sv
// settings from the command logic to the coalescing engine, and its per-vector coalescing-off flags back
`timescale 1ns/1ps
`default_nettype none
interface qifs_coal_if;
    import qifs_pkg::*;
    logic [7:0]         agg_time;
    logic [7:0]         aggregation_entry_threshold;
    logic               cfg_we;
    logic [VEC_W-1:0]   vector_select;
    logic               vector_coalesce_off;
    logic [NUM_VEC-1:0] off_flags;
    modport ctl  (output agg_time, aggregation_entry_threshold, cfg_we, vector_select,
                  vector_coalesce_off, input off_flags);
    modport coal (input agg_time, aggregation_entry_threshold, cfg_we, vector_select,
                  vector_coalesce_off, output off_flags);
endinterface
`default_nettype wire

//--- verilog/qifs_tick.sv
// divider giving a one-cycle enable every aggregation time unit
`timescale 1ns/1ps
`default_nettype none
module qifs_tick
    import qifs_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input  wire logic clk_sys,  // system clock
    input  wire logic rst_b,    // async reset, active low
    output logic      tick      // one pulse per unit
);
    logic [31:0] div_reg;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            div_reg <= 32'h0000_0000;
            tick    <= 1'b0;
        end else if (div_reg == 32'(TICK_CYCLES - 1)) begin
            div_reg <= 32'h0000_0000;
            tick    <= 1'b1;
        end else begin
            div_reg <= div_reg + 32'h0000_0001;
            tick    <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- verilog/qifs_coal.sv
// per-vector interrupt coalescing engine
`timescale 1ns/1ps
`default_nettype none
module qifs_coal
    import qifs_pkg::*;
(
    input  wire logic             clk_sys,     // system clock
    input  wire logic             rst_b,       // async reset, active low
    qifs_coal_if.coal             cfg,         // settings from command logic
    input  wire logic             tick,        // aggregation time unit pulse
    input  wire logic             post_valid,  // completion entry posted
    input  wire logic [VEC_W-1:0] post_vec,    // its vector
    input  wire logic             post_admin,  // entry is on the admin queue
    input  wire logic             post_error,  // entry carries error status
    input  wire logic             db_write,    // completion head doorbell written
    input  wire logic [VEC_W-1:0] db_vec,      // vector of that queue
    output logic                  fire_valid,  // interrupt to signal, pulse
    output logic [VEC_W-1:0]      fire_vec     // vector to signal
);
    logic [7:0]         cnt_reg [NUM_VEC];
    logic [7:0]         tmr_reg [NUM_VEC];
    logic [NUM_VEC-1:0] pend_reg;
    logic [NUM_VEC-1:0] fire_reg;
    logic [NUM_VEC-1:0] sel;
    logic               bypass;

    function automatic logic [NUM_VEC-1:0] lowest(input logic [NUM_VEC-1:0] v);
        return v & (~v + NUM_VEC'(1));
    endfunction

    function automatic logic [VEC_W-1:0] enc(input logic [NUM_VEC-1:0] v);
        logic [VEC_W-1:0] r;
        r = '0;
        for (int i = 0; i < NUM_VEC; i++) begin
            if (v[i]) r = VEC_W'(i);
        end
        return r;
    endfunction

    assign sel    = lowest(fire_reg);
    // admin entries and error completions bypass coalescing
    assign bypass = post_admin | post_error | cfg.off_flags[post_vec];

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cfg.off_flags <= '0;
        end else if (cfg.cfg_we) begin
            cfg.off_flags[cfg.vector_select] <= cfg.vector_coalesce_off;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pend_reg <= '0;
            fire_reg <= '0;
            for (int v = 0; v < NUM_VEC; v++) begin
                cnt_reg[v] <= 8'h00;
                tmr_reg[v] <= 8'h00;
            end
        end else begin
            for (int v = 0; v < NUM_VEC; v++) begin
                if (post_valid && post_vec == VEC_W'(v)) begin
                    if (bypass || cnt_reg[v] >= cfg.aggregation_entry_threshold) begin
                        fire_reg[v] <= 1'b1;
                        pend_reg[v] <= 1'b0;
                        cnt_reg[v]  <= 8'h00;
                        tmr_reg[v]  <= 8'h00;
                    end else begin
                        pend_reg[v] <= 1'b1;
                        cnt_reg[v]  <= cnt_reg[v] + 8'h01;
                        // a fire still being served must not be re-raised by a counted entry
                        if (sel[v]) fire_reg[v] <= 1'b0;
                    end
                end else if (db_write && db_vec == VEC_W'(v)) begin
                    // host is already draining: restart, which can postpone the interrupt
                    cnt_reg[v] <= 8'h00;
                    tmr_reg[v] <= 8'h00;
                    if (sel[v]) fire_reg[v] <= 1'b0;
                end else if (pend_reg[v] && tick && cfg.agg_time != 8'h00 &&
                             tmr_reg[v] + 8'h01 >= cfg.agg_time) begin
                    fire_reg[v] <= 1'b1;
                    pend_reg[v] <= 1'b0;
                    cnt_reg[v]  <= 8'h00;
                    tmr_reg[v]  <= 8'h00;
                end else begin
                    if (pend_reg[v] && tick) tmr_reg[v] <= tmr_reg[v] + 8'h01;
                    if (sel[v]) fire_reg[v] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fire_valid <= 1'b0;
            fire_vec   <= '0;
        end else begin
            fire_valid <= |fire_reg;
            fire_vec   <= enc(sel);
        end
    end
endmodule
`default_nettype wire

//--- verif/qifs_monitor.sv
// port assertions for the feature settings block
`timescale 1ns/1ps
`default_nettype none
module qifs_monitor
    import qifs_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input  wire logic        clk_sys,                // clock
    input  wire logic        rst_b,                  // reset
    input  wire logic        cmd_valid,              // offered
    input  wire logic [7:0]  cmd_fid,                // feature
    input  wire logic [31:0] cmd_dw11,               // dword 11
    input  wire logic        cmd_ready,              // takeable
    input  wire logic        cpl_valid,              // completion
    input  wire logic [31:0] cpl_dw0,                // result
    input  wire logic        post_valid,             // entry posted
    input  wire logic        post_admin,             // admin queue
    input  wire logic        post_error,             // error entry
    input  wire logic        vec_irq_valid,          // vector irq
    input  wire logic [15:0] crit_warn,              // warnings
    input  wire logic        aen_valid,              // notice
    input  wire logic [15:0] aen_bits,               // noticed bits
    input  wire logic        normal_atomic_unit_off, // atomic mode
    input  wire logic [7:0]  preboot_load_counter    // load count
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    wire logic take = cmd_valid && cmd_ready;
    wire logic pb   = take && cmd_fid == FID_PROGRESS;
    cpl_after_two_a: assert property (take |-> ##2 cpl_valid)
        else $error("completion late");
    cpl_single_a: assert property (cpl_valid |=> !cpl_valid)
        else $error("completion doubled");
    ready_gap_a: assert property (take |=> !cmd_ready [*2] ##1 cmd_ready)
        else $error("ready spacing wrong");
    alloc_range_a: assert property (take && cmd_fid == FID_NUM_QUEUES |-> ##2
        cpl_dw0[15:0] <= MAX_SQ_ZB && cpl_dw0[31:16] <= MAX_CQ_ZB) else $error("allocation out of range");
    atomic_apply_a: assert property (take && cmd_fid == FID_ATOMIC |-> ##2
        normal_atomic_unit_off == $past(cmd_dw11[DN_BIT], 2)) else $error("atomic mode wrong");
    count_apply_a: assert property (pb |-> ##2 preboot_load_counter == $past(cmd_dw11[7:0], 2))
        else $error("load count wrong");
    count_hold_a: assert property (!$past(pb, 2) |-> $stable(preboot_load_counter))
        else $error("load count drifted");
    fast_bypass_a: assert property (post_valid && (post_admin || post_error) |-> ##[2:9] vec_irq_valid)
        else $error("bypass interrupt missing");
    aen_rise_a: assert property (aen_valid |-> (aen_bits & ($past(crit_warn, 2) | ~$past(crit_warn))) == 16'h0000)
        else $error("notice without rise");
    cover property (take && cmd_fid == FID_COALESCE);
    cover property (take && cmd_fid == FID_VEC_CFG);
    cover property (aen_valid);
endmodule
bind qifs_top qifs_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon (.clk_sys, .rst_b, .cmd_valid, .cmd_fid, .cmd_dw11,
    .cmd_ready, .cpl_valid, .cpl_dw0, .post_valid, .post_admin, .post_error, .vec_irq_valid, .crit_warn,
    .aen_valid, .aen_bits, .normal_atomic_unit_off, .preboot_load_counter);
`default_nettype wire

//--- verif/qifs_host.sv
// host software model issuing set-feature commands
`timescale 1ns/1ps
`default_nettype none
module qifs_host
    import qifs_pkg::*;
(
    input  wire logic        clk_sys,   // clock
    input  wire logic        cmd_ready, // takeable
    output logic             cmd_valid, // offered
    output logic [7:0]       cmd_fid,   // feature
    output logic [31:0]      cmd_dw11   // dword 11
);
    logic [39:0] cq[$];
    logic [7:0]  load_cnt = 8'h00;
    initial cmd_valid = 1'b0;
    initial cmd_fid = 8'h00;
    initial cmd_dw11 = 32'h0;
    task automatic send(input logic [7:0] fid, input logic [31:0] dw, input logic [39:0] exp);
        cq.push_back(exp);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_fid <= fid;
        cmd_dw11 <= dw;
        do @(posedge clk_sys); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        cmd_fid <= ~fid;
        cmd_dw11 <= ~dw;
    endtask
    task automatic ask_queues(input logic [15:0] cqn, sqn, input logic [31:0] alloc);
        send(FID_NUM_QUEUES, {cqn, sqn}, {ST_OK, alloc});
    endtask
    task automatic set_count(input logic [7:0] v);
        load_cnt = v;
        send(FID_PROGRESS, {24'h0, v}, {ST_OK, 32'h0});
    endtask
    task automatic boot_done();
        if (load_cnt != 8'hFF) set_count(load_cnt + 8'h01);
    endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench of the feature settings block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import qifs_pkg::*;
    localparam logic [39:0] OK = {ST_OK, 32'h0};
    logic clk_sys = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, post_valid = 0, post_admin = 0, post_error = 0;
    logic db_write = 0, cmd_valid, cmd_ready, cpl_valid, vec_irq_valid, aen_valid, normal_atomic_unit_off, irq;
    logic [2:0] post_vec = 0, db_vec = 0, vec_irq_vec, vq[$];
    logic [7:0] reg_addr = 0, cmd_fid, cpl_status, preboot_load_counter;
    logic [15:0] crit_warn = 0, aen_bits, cqn, sqn, aq[$];
    logic [31:0] reg_wdata = 0, reg_rdata, cmd_dw11, cpl_dw0, alloc, seed = 32'hde84;
    int fails = 0;
    int checks_done = 0;
    always #4 clk_sys = ~clk_sys;
    qifs_top #(.TICK_CYCLES(4)) dut (.clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .cmd_valid, .cmd_fid, .cmd_dw11, .cmd_ready, .cpl_valid, .cpl_dw0, .cpl_status, .post_valid, .post_vec,
        .post_admin, .post_error, .db_write, .db_vec, .vec_irq_valid, .vec_irq_vec, .crit_warn, .aen_valid,
        .aen_bits, .normal_atomic_unit_off, .preboot_load_counter, .irq);
    qifs_host host (.clk_sys, .cmd_ready, .cmd_valid, .cmd_fid, .cmd_dw11);
    task automatic chk(input logic [63:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        // read data stand only in the cycle after the strobe
        @(posedge clk_sys);
        if (!w) chk(reg_rdata, d);
    endtask
    task automatic post(input logic [2:0] v, input logic adm, err, fire, db);
        if (fire) vq.push_back(v);
        @(posedge clk_sys);
        post_valid <= !db;
        db_write <= db;
        post_vec <= v;
        db_vec <= v;
        post_admin <= adm;
        post_error <= err;
        @(posedge clk_sys);
        post_valid <= 1'b0;
        db_write <= 1'b0;
        post_vec <= ~v;
    endtask
    // completions, vector interrupts and notices are matched against the oldest note
    always @(posedge clk_sys) begin
        // an empty queue gives all ones, which no seen value can match
        if (cpl_valid) chk({cpl_status, cpl_dw0}, host.cq.size() ? 64'(host.cq.pop_front()) : '1);
        if (vec_irq_valid) chk(vec_irq_vec, vq.size() ? 64'(vq.pop_front()) : '1);
        if (aen_valid) chk(aen_bits, aq.size() ? 64'(aq.pop_front()) : '1);
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #200000;
        fails++;
        test_done();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
        bus(0, ADDR_COAL, 0);
        bus(0, ADDR_VOFF, 0);
        bus(0, 8'h1C, 0);
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        cqn = {11'h0, seed[20:16]};
        sqn = {11'h0, seed[4:0]};
        alloc = {(cqn > MAX_CQ_ZB) ? MAX_CQ_ZB : cqn, (sqn > MAX_SQ_ZB) ? MAX_SQ_ZB : sqn};
        host.ask_queues(cqn, sqn, alloc);
        host.send(FID_NUM_QUEUES, ~{cqn, sqn}, {ST_OK, alloc});
        bus(0, ADDR_ALLOC, alloc);
        $display("queue counts done");
        bus(1, ADDR_MASK, 1);
        host.send(FID_COALESCE, 32'h0001, OK);
        post(1, 0, 0, 0, 0);
        post(1, 0, 0, 1, 0);
        post(2, 1, 0, 1, 0);
        post(3, 0, 1, 1, 0);
        post(4, 0, 0, 0, 0);
        post(4, 0, 0, 0, 1);
        post(4, 0, 0, 0, 0);
        post(4, 0, 0, 1, 0);
        host.send(FID_VEC_CFG, 32'h1_0005, OK);
        post(5, 0, 0, 1, 0);
        host.send(FID_VEC_CFG, 32'h1_0009, {ST_INV_FIELD, 32'h0});
        repeat (4) @(posedge clk_sys);
        chk(irq, 1);
        bus(0, ADDR_STATUS, 5);
        bus(1, ADDR_STATUS, 7);
        repeat (2) @(posedge clk_sys);
        chk(irq, 0);
        host.send(FID_COALESCE, 32'h02FF, OK);
        post(6, 0, 0, 1, 0);
        $display("coalescing done");
        host.send(FID_ASYNC_EV, 32'h0008, OK);
        repeat (3) @(posedge clk_sys);
        aq.push_back(16'h0008);
        crit_warn <= 16'h0018;
        host.send(FID_ATOMIC, 32'h1, OK);
        repeat (3) @(posedge clk_sys);
        bus(0, ADDR_MISC, 32'h8001_0008);
        host.set_count(8'hFE);
        host.boot_done();
        host.boot_done();
        repeat (3) @(posedge clk_sys);
        chk(preboot_load_counter, 8'hFF);
        host.set_count(8'h00);
        repeat (3) @(posedge clk_sys);
        bus(0, ADDR_PREBOOT_LOAD_COUNTER, 0);
        $display("events and load count done");
        repeat (40) @(posedge clk_sys);
        chk(vq.size() + aq.size() + host.cq.size(), 0);
        test_done();
    end
endmodule
`default_nettype wire
